/* logic/smts_unit.sv */
// Segment translation unit: table select, descriptors, violation capture.
// Assumes the master end keeps the unit reset line and chip select rules.
// Overview of operation
// - Range flag picks names 64-127 or 0-63
// - Name bit 6 must equal range flag
// - Multi-table: mode line must match match flag
// - Mode mismatch gives no translated address
// - Table select flags writable at run time
// - Master drives mode line low in system
// - Reset clears mode; addresses pass untranslated
// - System holds chip select during reset
// - Quiet during I/O and refresh cycles
// - System routes suppress to memory and DMA
// - Low command byte bits select units
// - Bytes 0-1 hold base upper 16 bits
// - Byte 2 holds length blocks minus one
// - Byte 3 holds attributes, bit0 read-only
// - Opcode 0B writes four descriptor bytes
// - Opcode 01 loads the descriptor index
// - Read-only over-limit write reports type 05
// - Bus status nibbles: direction/mode, cycle kind
// - Violation segment keeps full seven-bit name
// - Violation offset keeps only high byte
// - Trap acknowledge drives line 8 plus id
// - Chip select at reset sets master enable
// - Out-of-range name: no address, no request
module smts_unit (
   input wire logic clk_in,
   input wire logic sys_rst_in,
   smts_if.unit bus,
   output logic master_enable_flag_out,
   output logic translate_out,
   output logic [5:0] descriptor_index_reg_out,
   output logic [7:0] violation_type_out
);
   typedef struct packed {
      logic [7:0] mode;
      logic [5:0] descriptor_index_reg;
      logic [1:0] byte_ptr;
      logic [smts_pkg::NUM_DESC-1:0][15:0] base;
      logic [smts_pkg::NUM_DESC-1:0][7:0] limit;
      logic [smts_pkg::NUM_DESC-1:0][7:0] attr;
      logic [7:0] vtr;
      logic [6:0] vsn;
      logic [7:0] voff;
      logic [7:0] vbs;
      logic trap;
      logic [23:0] phys_addr;
      logic phys_valid;
      logic suppress;
      logic [15:0] ad_out;
      logic ad_oe_n;
   } smts_unit_state_t;

   smts_unit_state_t s;
   smts_unit_state_t next_s;

   function automatic logic smts_unit_hit(input logic [7:0] mode, input logic [6:0] seg,
                                          input logic ns);
      logic range_ok;
      logic table_ok;
      range_ok = seg[smts_pkg::SEG_RANGE_BIT] == mode[smts_pkg::MODE_URS];
      table_ok = !mode[smts_pkg::MODE_MST] || (ns == mode[smts_pkg::MODE_NMS]);
      return mode[smts_pkg::MODE_MASTER_ENABLE_FLAG] && range_ok && table_ok;
   endfunction

   function automatic logic smts_unit_mem_cycle(input logic [3:0] kind);
      return (kind == smts_pkg::CYC_DATA) || (kind == smts_pkg::CYC_FETCH);
   endfunction

   always_comb begin
      logic [5:0] idx;
      logic [7:0] rd;
      logic rd_en;
      logic len_bad;
      logic ro_bad;
      logic [2:0] id;
      idx = bus.seg_name[5:0];
      rd = 8'h00;
      rd_en = 1'b0;
      len_bad = 1'b0;
      ro_bad = 1'b0;
      id = s.mode[smts_pkg::MODE_ID_MSB:0];
      next_s = s;
      next_s.phys_valid = 1'b0;
      next_s.suppress = 1'b0;
      next_s.ad_oe_n = 1'b1;
      next_s.ad_out = 16'h0000;
      if (bus.reset_line) begin
         next_s.mode = smts_pkg::MODE_RESET;
         next_s.vtr = smts_pkg::VTR_RESET;
         next_s.byte_ptr = 2'd0;
         next_s.trap = 1'b0;
         if (!bus.cs_n) begin
            next_s.mode[smts_pkg::MODE_MASTER_ENABLE_FLAG] = 1'b1;
         end
      end else begin
         // Chip select comes from one low command byte bit
         if (bus.cmd_valid && !bus.cs_n) begin
            case (bus.cmd_word[15:8])
               smts_pkg::OP_MODE: begin
                  if (bus.cmd_write) begin
                     next_s.mode = bus.cmd_data;
                  end else begin
                     rd = s.mode;
                     rd_en = 1'b1;
                  end
               end
               smts_pkg::OP_SAR: begin
                  if (bus.cmd_write) begin
                     next_s.descriptor_index_reg = bus.cmd_data[5:0];
                  end else begin
                     rd = {2'b00, s.descriptor_index_reg};
                     rd_en = 1'b1;
                  end
                  next_s.byte_ptr = 2'd0;
               end
               smts_pkg::OP_DESC: begin
                  // Bytes arrive in sequence; pointer restarts on index load
                  case (s.byte_ptr)
                     2'd0: begin
                        rd = s.base[s.descriptor_index_reg][15:8];
                        if (bus.cmd_write) begin
                           next_s.base[s.descriptor_index_reg][15:8] = bus.cmd_data;
                        end
                     end
                     2'd1: begin
                        rd = s.base[s.descriptor_index_reg][7:0];
                        if (bus.cmd_write) begin
                           next_s.base[s.descriptor_index_reg][7:0] = bus.cmd_data;
                        end
                     end
                     2'd2: begin
                        rd = s.limit[s.descriptor_index_reg];
                        if (bus.cmd_write) begin
                           next_s.limit[s.descriptor_index_reg] = bus.cmd_data;
                        end
                     end
                     default: begin
                        rd = s.attr[s.descriptor_index_reg];
                        if (bus.cmd_write) begin
                           next_s.attr[s.descriptor_index_reg] = bus.cmd_data;
                        end
                     end
                  endcase
                  rd_en = !bus.cmd_write;
                  next_s.byte_ptr = s.byte_ptr + 2'd1;
               end
               smts_pkg::OP_VTR: begin
                  rd = s.vtr;
                  rd_en = 1'b1;
               end
               smts_pkg::OP_VSN: begin
                  rd = {1'b0, s.vsn};
                  rd_en = 1'b1;
               end
               smts_pkg::OP_VOFF: begin
                  rd = s.voff;
                  rd_en = 1'b1;
               end
               smts_pkg::OP_VBS: begin
                  rd = s.vbs;
                  rd_en = 1'b1;
               end
               smts_pkg::OP_RST_VTR: begin
                  next_s.vtr = smts_pkg::VTR_RESET;
               end
               default: begin
               end
            endcase
            if (rd_en) begin
               next_s.ad_out = {8'h00, rd};
               next_s.ad_oe_n = 1'b0;
            end
         end
         // Placed after commands so a new violation beats a same-cycle clear
         if (bus.acc_valid && smts_unit_mem_cycle(bus.cycle_kind) &&
             smts_unit_hit(s.mode, bus.seg_name, bus.normal_mode)) begin
            next_s.phys_valid = 1'b1;
            if (s.mode[smts_pkg::MODE_TRANSLATE]) begin
               next_s.phys_addr = {s.base[idx], 8'h00} + {8'h00, bus.offset};
               len_bad = bus.offset[15:8] > s.limit[idx];
               ro_bad = bus.acc_write && s.attr[idx][smts_pkg::ATTR_READ_ONLY];
            end else begin
               next_s.phys_addr = {1'b0, bus.seg_name, bus.offset};
            end
            if (len_bad || ro_bad) begin
               next_s.suppress = 1'b1;
               next_s.trap = 1'b1;
               // Built on next_s so a same-cycle clear keeps the other bits clear
               next_s.vtr[smts_pkg::VT_LENGTH] = next_s.vtr[smts_pkg::VT_LENGTH] | len_bad;
               next_s.vtr[smts_pkg::VT_READ_ONLY] = next_s.vtr[smts_pkg::VT_READ_ONLY] | ro_bad;
               next_s.vsn = bus.seg_name;
               next_s.voff = bus.offset[15:8];
               next_s.vbs = {2'b00, bus.acc_write, !bus.normal_mode, bus.cycle_kind};
            end
         end
         if (bus.trap_ack && s.trap) begin
            next_s.ad_out = 16'h0000;
            next_s.ad_out[smts_pkg::TRAP_LINE_BASE + int'(id)] = 1'b1;
            next_s.ad_oe_n = 1'b0;
            // A violation in the acknowledge cycle keeps the trap raised
            next_s.trap = len_bad || ro_bad;
         end
      end
   end

   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         s <= '0;
         s.ad_oe_n <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign bus.phys_addr = s.phys_addr;
   assign bus.phys_valid = s.phys_valid;
   assign bus.suppress = s.suppress;
   assign bus.seg_trap = s.trap;
   assign bus.ad_out = s.ad_out;
   assign bus.ad_oe_n = s.ad_oe_n;
   assign master_enable_flag_out = s.mode[smts_pkg::MODE_MASTER_ENABLE_FLAG];
   assign translate_out = s.mode[smts_pkg::MODE_TRANSLATE];
   assign descriptor_index_reg_out = s.descriptor_index_reg;
   assign violation_type_out = s.vtr;
endmodule // smts_unit

/* logic/smts_pkg.sv */
// Shared constants for the segment translation unit and its bus master.
// Assumes one clock (clk_in) and an asynchronous active-high reset.
package smts_pkg;
   // Command opcodes, high byte of the command word
   localparam logic [7:0] OP_MODE = 8'h00;
   localparam logic [7:0] OP_SAR = 8'h01;
   localparam logic [7:0] OP_VTR = 8'h02;
   localparam logic [7:0] OP_VSN = 8'h03;
   localparam logic [7:0] OP_VOFF = 8'h04;
   localparam logic [7:0] OP_VBS = 8'h05;
   localparam logic [7:0] OP_DESC = 8'h0B;
   localparam logic [7:0] OP_RST_VTR = 8'h11;
   // Mode register fields
   localparam int MODE_MASTER_ENABLE_FLAG = 7;
   localparam int MODE_TRANSLATE = 6;
   localparam int MODE_URS = 5;
   localparam int MODE_MST = 4;
   localparam int MODE_NMS = 3;
   localparam int MODE_ID_MSB = 2;
   localparam logic [7:0] MODE_RESET = 8'h00;
   // Segment name range bit
   localparam int SEG_RANGE_BIT = 6;
   // Violation type and attribute fields
   localparam int VT_LENGTH = 0;
   localparam int VT_READ_ONLY = 2;
   localparam int ATTR_READ_ONLY = 0;
   localparam logic [7:0] VTR_RESET = 8'h00;
   // Bus status: high nibble direction and mode, low nibble cycle kind
   localparam int VBS_WRITE = 5;
   localparam int VBS_SYSTEM = 4;
   localparam logic [3:0] CYC_DATA = 4'h8;
   localparam logic [3:0] CYC_FETCH = 4'hD;
   localparam logic [3:0] CYC_IO = 4'h2;
   localparam logic [3:0] CYC_REFRESH = 4'h1;
   // Trap acknowledge drives address/data line TRAP_LINE_BASE + id
   localparam int TRAP_LINE_BASE = 8;
   // Descriptor storage
   localparam int NUM_DESC = 64;
   localparam int DESC_BYTES = 4;
   // Master end: the unit reset line is held this many cycles plus one after system reset
   localparam logic [2:0] RESET_HOLD_CYCLES = 3'h4;
endpackage

/* logic/smts_if.sv */
// Link between the bus master end and one segment translation unit.
// The address/data wire level is resolved here from the unit's enable.
interface smts_if;
   logic cs_n;
   logic reset_line;
   logic cmd_valid;
   logic [15:0] cmd_word;
   logic [7:0] cmd_data;
   logic cmd_write;
   logic acc_valid;
   logic [6:0] seg_name;
   logic [15:0] offset;
   logic acc_write;
   logic normal_mode;
   logic [3:0] cycle_kind;
   logic trap_ack;
   logic [23:0] phys_addr;
   logic phys_valid;
   logic suppress;
   logic seg_trap;
   logic [15:0] ad_out;
   logic ad_oe_n;
   logic [15:0] ad_level;

   // Undriven wire reads as zero
   assign ad_level = ad_oe_n ? 16'h0000 : ad_out;

   modport unit (
      input cs_n, reset_line, cmd_valid, cmd_word, cmd_data, cmd_write,
      input acc_valid, seg_name, offset, acc_write, normal_mode, cycle_kind, trap_ack,
      output phys_addr, phys_valid, suppress, seg_trap, ad_out, ad_oe_n
   );
   modport master (
      output cs_n, reset_line, cmd_valid, cmd_word, cmd_data, cmd_write,
      output acc_valid, seg_name, offset, acc_write, normal_mode, cycle_kind, trap_ack,
      input phys_addr, phys_valid, suppress, seg_trap, ad_level
   );
endinterface

/* logic/smts_master.sv */
// Bus master end: issues commands and accesses to one translation unit.
// Assumes the user side holds requests steady only for the cycle given.
module smts_master #(
   parameter int UNIT_BIT = 1,
   parameter bit SET_ENABLE = 1'b1
) (
   input wire logic clk_in,
   input wire logic sys_rst_in,
   smts_if.master bus,
   output logic ready_out,
   input wire logic cmd_valid_in,
   input wire logic [15:0] cmd_word_in,
   input wire logic [7:0] cmd_data_in,
   input wire logic cmd_write_in,
   input wire logic acc_valid_in,
   input wire logic [6:0] seg_name_in,
   input wire logic [15:0] offset_in,
   input wire logic acc_write_in,
   input wire logic normal_mode_in,
   input wire logic [3:0] cycle_kind_in,
   input wire logic trap_ack_in,
   output logic [7:0] rd_data_out,
   output logic rd_valid_out,
   output logic [15:0] ack_lines_out,
   output logic [23:0] phys_addr_out,
   output logic phys_valid_out,
   output logic suppress_out,
   output logic seg_trap_out
);
   typedef enum logic {SMTS_HOLD, SMTS_RUN} smts_master_phase_t;
   typedef struct packed {
      smts_master_phase_t phase;
      logic [2:0] hold_cnt;
      logic ack_wait;
      logic cs_n;
      logic reset_line;
      logic cmd_valid;
      logic [15:0] cmd_word;
      logic [7:0] cmd_data;
      logic cmd_write;
      logic acc_valid;
      logic [6:0] seg_name;
      logic [15:0] offset;
      logic acc_write;
      logic normal_mode;
      logic [3:0] cycle_kind;
      logic trap_ack;
      logic [7:0] rd_data;
      logic rd_valid;
      logic [15:0] ack_lines;
      logic [23:0] phys_addr;
      logic phys_valid;
      logic suppress;
   } smts_master_state_t;

   smts_master_state_t s;
   smts_master_state_t next_s;

   always_comb begin
      next_s = s;
      next_s.cmd_valid = 1'b0;
      next_s.acc_valid = 1'b0;
      next_s.trap_ack = 1'b0;
      next_s.rd_valid = 1'b0;
      next_s.phys_valid = bus.phys_valid;
      next_s.suppress = bus.suppress;
      if (bus.phys_valid) begin
         next_s.phys_addr = bus.phys_addr;
      end
      case (s.phase)
         SMTS_HOLD: begin
            next_s.reset_line = 1'b1;
            next_s.cs_n = !SET_ENABLE;
            if (s.hold_cnt == smts_pkg::RESET_HOLD_CYCLES) begin
               next_s.phase = SMTS_RUN;
               next_s.reset_line = 1'b0;
               next_s.cs_n = 1'b1;
            end else begin
               next_s.hold_cnt = s.hold_cnt + 3'd1;
            end
         end
         SMTS_RUN: begin
            next_s.cs_n = 1'b1;
            if (cmd_valid_in) begin
               next_s.cmd_valid = 1'b1;
               next_s.cmd_word = cmd_word_in;
               next_s.cmd_data = cmd_data_in;
               next_s.cmd_write = cmd_write_in;
               next_s.cs_n = !cmd_word_in[UNIT_BIT];
            end else if (acc_valid_in) begin
               next_s.acc_valid = 1'b1;
               next_s.seg_name = seg_name_in;
               next_s.offset = offset_in;
               next_s.acc_write = acc_write_in;
               next_s.normal_mode = normal_mode_in;
               next_s.cycle_kind = cycle_kind_in;
            end else if (trap_ack_in) begin
               next_s.trap_ack = 1'b1;
               next_s.ack_wait = 1'b1;
            end
            // Unit answers one edge after it sees the acknowledge on the link
            if (s.ack_wait && !s.trap_ack) begin
               next_s.ack_lines = bus.ad_level;
               next_s.ack_wait = 1'b0;
            end else if (!s.ack_wait && bus.ad_level != 16'h0000) begin
               next_s.rd_data = bus.ad_level[7:0];
               next_s.rd_valid = 1'b1;
            end
         end
         default: begin
            next_s.phase = SMTS_HOLD;
         end
      endcase
   end

   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         s <= '0;
         s.cs_n <= 1'b1;
         s.reset_line <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   assign bus.cs_n = s.cs_n;
   assign bus.reset_line = s.reset_line;
   assign bus.cmd_valid = s.cmd_valid;
   assign bus.cmd_word = s.cmd_word;
   assign bus.cmd_data = s.cmd_data;
   assign bus.cmd_write = s.cmd_write;
   assign bus.acc_valid = s.acc_valid;
   assign bus.seg_name = s.seg_name;
   assign bus.offset = s.offset;
   assign bus.acc_write = s.acc_write;
   assign bus.normal_mode = s.normal_mode;
   assign bus.cycle_kind = s.cycle_kind;
   assign bus.trap_ack = s.trap_ack;
   assign ready_out = (s.phase == SMTS_RUN);
   assign rd_data_out = s.rd_data;
   assign rd_valid_out = s.rd_valid;
   assign ack_lines_out = s.ack_lines;
   assign phys_addr_out = s.phys_addr;
   assign phys_valid_out = s.phys_valid;
   assign suppress_out = s.suppress;
   assign seg_trap_out = bus.seg_trap;
endmodule // smts_master

/* sim/smts_link_sva.sv */
// Checker for the link between the bus master end and one translation unit.
// Assumes one clock, asynchronous active-high reset, and UNIT_BIT = 1.
module smts_link_sva (
   input wire logic clk_in,
   input wire logic sys_rst_in,
   input wire logic cs_n,
   input wire logic reset_line,
   input wire logic cmd_valid,
   input wire logic [15:0] cmd_word,
   input wire logic [7:0] cmd_data,
   input wire logic cmd_write,
   input wire logic acc_valid,
   input wire logic [6:0] seg_name,
   input wire logic [15:0] offset,
   input wire logic normal_mode,
   input wire logic [3:0] cycle_kind,
   input wire logic trap_ack,
   input wire logic [23:0] phys_addr,
   input wire logic phys_valid,
   input wire logic seg_trap,
   input wire logic [15:0] ad_out,
   input wire logic ad_oe_n
);
   logic [7:0] mode;
   logic kind_ok;
   logic hit;

   // Mirror of the mode register, built from the reset line and taken mode commands only
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         mode <= 8'h00;
      end else if (reset_line) begin
         mode <= cs_n ? 8'h00 : 8'h80;
      end else if (cmd_valid && !cs_n && cmd_write && cmd_word[15:8] == smts_pkg::OP_MODE) begin
         mode <= cmd_data;
      end
   end

   assign kind_ok = cycle_kind == smts_pkg::CYC_DATA || cycle_kind == smts_pkg::CYC_FETCH;
   assign hit = mode[7] && seg_name[6] == mode[5] && (!mode[4] || normal_mode == mode[3]) && kind_ok;

   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (sys_rst_in);

   a_hit_answers: assert property (acc_valid && hit |=> phys_valid)
      else $error("accepted access gave no address");
   a_miss_silent: assert property (acc_valid && !mode[7] |=> !phys_valid)
      else $error("disabled unit gave an address");
   a_range_miss: assert property (acc_valid && seg_name[6] != mode[5] |=> !phys_valid)
      else $error("out of range name gave an address");
   a_mode_mismatch: assert property (acc_valid && mode[4] && normal_mode != mode[3] |=> !phys_valid)
      else $error("mode mismatch gave an address");
   a_io_quiet: assert property (acc_valid && !kind_ok |=> !phys_valid)
      else $error("io or refresh cycle gave an address");
   a_pass_through: assert property (acc_valid && hit && !mode[6] |=>
      phys_addr == {1'b0, $past(seg_name), $past(offset)})
      else $error("untranslated address wrong");
   a_ack_line: assert property (trap_ack && seg_trap |=> !ad_oe_n && !seg_trap &&
      ad_out == (16'h0001 << (smts_pkg::TRAP_LINE_BASE + mode[2:0])))
      else $error("trap acknowledge line wrong");
   a_trap_holds: assert property (seg_trap && !trap_ack && !reset_line |=> seg_trap)
      else $error("trap dropped without acknowledge");
   a_read_answer: assert property (cmd_valid && !cs_n && !cmd_write &&
      cmd_word[15:8] <= smts_pkg::OP_VBS |=> !ad_oe_n)
      else $error("selected read not answered");
   a_unselected_quiet: assert property (cmd_valid && cs_n |=> ad_oe_n)
      else $error("unselected unit drove the bus");
endmodule // smts_link_sva

/* sim/test_segment_mmu_table_select.sv */
// Self-checking bench: master end and translation unit joined by smts_if.
// Assumes the master selects the unit by command bit 1 and sets enable at reset.
module test_segment_mmu_table_select;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_in, sys_rst_in, ready_out, cmd_valid_in, cmd_write_in, acc_valid_in;
   logic acc_write_in, normal_mode_in, trap_ack_in, rd_valid_out, phys_valid_out;
   logic suppress_out, seg_trap_out, mef, tr;
   logic [15:0] cmd_word_in, offset_in, ack_lines_out;
   logic [7:0] cmd_data_in, rd_data_out, vt;
   logic [6:0] seg_name_in;
   logic [3:0] cycle_kind_in;
   logic [23:0] phys_addr_out;
   logic [5:0] dix;
   logic [24:0] q_phys[$];
   logic [7:0] q_rd[$];
   // Descriptor: base 1152, three blocks, read-only
   logic [7:0] own_bytes[4] = '{8'h11, 8'h52, 8'h02, 8'h01};
   int failures = 0;
   int checks_done = 0;
   int seed = 32'h4ada4261;
   smts_if link ();
   smts_master i_smts_master (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .bus(link),
      .ready_out(ready_out), .cmd_valid_in(cmd_valid_in), .cmd_word_in(cmd_word_in),
      .cmd_data_in(cmd_data_in), .cmd_write_in(cmd_write_in), .acc_valid_in(acc_valid_in),
      .seg_name_in(seg_name_in), .offset_in(offset_in), .acc_write_in(acc_write_in),
      .normal_mode_in(normal_mode_in), .cycle_kind_in(cycle_kind_in), .trap_ack_in(trap_ack_in),
      .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out), .ack_lines_out(ack_lines_out),
      .phys_addr_out(phys_addr_out), .phys_valid_out(phys_valid_out),
      .suppress_out(suppress_out), .seg_trap_out(seg_trap_out));
   smts_unit i_smts_unit (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .bus(link),
      .master_enable_flag_out(mef), .translate_out(tr), .descriptor_index_reg_out(dix),
      .violation_type_out(vt));
   smts_link_sva i_smts_link_sva (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .cs_n(link.cs_n),
      .reset_line(link.reset_line), .cmd_valid(link.cmd_valid), .cmd_word(link.cmd_word),
      .cmd_data(link.cmd_data), .cmd_write(link.cmd_write), .acc_valid(link.acc_valid),
      .seg_name(link.seg_name), .offset(link.offset), .normal_mode(link.normal_mode),
      .cycle_kind(link.cycle_kind), .trap_ack(link.trap_ack), .phys_addr(link.phys_addr),
      .phys_valid(link.phys_valid), .seg_trap(link.seg_trap), .ad_out(link.ad_out),
      .ad_oe_n(link.ad_oe_n));

   always #20 clk_in = ~clk_in;

   task automatic results();
      if (failures == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic fail(input string msg);
      failures++;
      $display("Error %0t: %s", $time, msg);
   endtask
   task automatic check_phys(input logic [24:0] exp, input logic [24:0] got);
      checks_done++;
      if (got !== exp) fail($sformatf("address %h, expected %h", got, exp));
   endtask
   task automatic check_rd(input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp) fail($sformatf("read %h, expected %h", got, exp));
   endtask
   task automatic check_line(input logic [15:0] exp, input logic [15:0] got);
      checks_done++;
      if (got !== exp) fail($sformatf("status %h, expected %h", got, exp));
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask
   task automatic cmd(input logic [15:0] word, input logic [7:0] data, input logic wr);
      cmd_word_in = word;
      cmd_data_in = data;
      cmd_write_in = wr;
      cmd_valid_in = 1'b1;
      tick(1);
      cmd_valid_in = 1'b0;
      tick(3);
   endtask
   task automatic rd(input logic [7:0] op, input logic [7:0] exp);
      q_rd.push_back(exp);
      cmd({op, 8'h02}, 8'h00, 1'b0);
   endtask
   task automatic acc(input logic [6:0] sg, input logic [15:0] off, input logic wr, input logic nm,
                      input logic [3:0] kind, input logic take, input logic [24:0] exp);
      if (take) q_phys.push_back(exp);
      seg_name_in = sg;
      offset_in = off;
      acc_write_in = wr;
      normal_mode_in = nm;
      cycle_kind_in = kind;
      acc_valid_in = 1'b1;
      tick(1);
      acc_valid_in = 1'b0;
      tick(4);
   endtask
   function automatic logic [24:0] xl(input logic [15:0] base, input logic [15:0] off,
                                      input logic sup);
      return {sup, {base, 8'h00} + {8'h00, off}};
   endfunction

   // Results arrive in order, so each is paired with the oldest note
   // Sampled mid-cycle, away from the edge that launches the outputs
   always @(negedge clk_in) begin
      if (phys_valid_out === 1'b1) begin
         if (q_phys.size() == 0) fail("unexpected address");
         else check_phys(q_phys.pop_front(), {suppress_out, phys_addr_out});
      end
      if (rd_valid_out === 1'b1) begin
         if (q_rd.size() == 0) fail("unexpected read data");
         else check_rd(q_rd.pop_front(), rd_data_out);
      end
   end

   initial begin
      #4000000;
      fail("timeout");
      results();
   end

   initial begin
      logic [6:0] sg;
      logic [15:0] of;
      logic w;
      logic own;
      {clk_in, cmd_valid_in, cmd_write_in, acc_valid_in, acc_write_in} = 5'h00;
      {normal_mode_in, trap_ack_in, cmd_word_in, offset_in, cmd_data_in} = 42'h0;
      {seg_name_in, cycle_kind_in} = 11'h000;
      sys_rst_in = 1'b1;
      tick(20);
      sys_rst_in = 1'b0;
      for (int i = 0; i < 50 && ready_out !== 1'b1; i++) tick(1);
      if (ready_out !== 1'b1) fail("master never ready");
      check_line(16'h0001, {15'h0000, mef});
      check_line(16'h0000, {15'h0000, tr});
      acc(7'h05, 16'h1234, 1'b0, 1'b1, smts_pkg::CYC_DATA, 1'b1, 25'h005_1234);
      acc(7'h45, 16'h1234, 1'b0, 1'b1, smts_pkg::CYC_DATA, 1'b0, '0);
      rd(smts_pkg::OP_MODE, 8'h80);
      cmd(16'h0102, 8'h01, 1'b1);
      check_line(16'h0001, {10'h000, dix});
      foreach (own_bytes[i]) cmd(16'h0B02, own_bytes[i], 1'b1);
      cmd(16'h0002, 8'hE2, 1'b1);
      check_line(16'h0001, {15'h0000, tr});
      acc(7'h41, 16'h0128, 1'b0, 1'b1, smts_pkg::CYC_DATA, 1'b1, xl(16'h1152, 16'h0128, 1'b0));
      acc(7'h41, 16'h02FF, 1'b0, 1'b0, smts_pkg::CYC_FETCH, 1'b1, xl(16'h1152, 16'h02FF, 1'b0));
      acc(7'h01, 16'h0128, 1'b0, 1'b1, smts_pkg::CYC_DATA, 1'b0, '0);
      acc(7'h41, 16'h0128, 1'b0, 1'b1, smts_pkg::CYC_IO, 1'b0, '0);
      acc(7'h41, 16'h0128, 1'b0, 1'b1, smts_pkg::CYC_REFRESH, 1'b0, '0);
      acc(7'h41, 16'h9328, 1'b1, 1'b1, smts_pkg::CYC_DATA, 1'b1, xl(16'h1152, 16'h9328, 1'b1));
      check_line(16'h0005, {8'h00, vt});
      check_line(16'h0001, {15'h0000, seg_trap_out});
      rd(smts_pkg::OP_VTR, 8'h05);
      rd(smts_pkg::OP_VBS, 8'h28);
      rd(smts_pkg::OP_VSN, 8'h41);
      rd(smts_pkg::OP_VOFF, 8'h93);
      trap_ack_in = 1'b1;
      tick(1);
      trap_ack_in = 1'b0;
      for (int i = 0; i < 20 && ack_lines_out === 16'h0000; i++) tick(1);
      check_line(16'h0400, ack_lines_out);
      check_line(16'h0000, {15'h0000, seg_trap_out});
      cmd({smts_pkg::OP_RST_VTR, 8'h02}, 8'h00, 1'b1);
      check_line(16'h0000, {8'h00, vt});
      repeat (12) begin
         sg = 7'($random(seed));
         of = 16'($random(seed));
         w = 1'($random(seed));
         own = sg[5:0] == 6'h01;
         acc(sg, of, w, 1'b1, smts_pkg::CYC_DATA, sg[6], own ?
             xl(16'h1152, of, of[15:8] > 8'h02 || w) : xl(16'h0000, of, of[15:8] != 8'h00));
      end
      for (int m = 0; m < 2; m++) begin
         cmd(16'h0002, 8'hF2 | 8'(m << 3), 1'b1);
         for (int n = 0; n < 2; n++) begin
            acc(7'h41, 16'h0010, 1'b0, 1'(n), smts_pkg::CYC_DATA, n == m,
                xl(16'h1152, 16'h0010, 1'b0));
         end
      end
      cmd(16'h0004, 8'h00, 1'b1);
      acc(7'h41, 16'h0010, 1'b0, 1'b1, smts_pkg::CYC_DATA, 1'b1, xl(16'h1152, 16'h0010, 1'b0));
      cmd(16'h0006, 8'h00, 1'b1);
      check_line(16'h0000, {15'h0000, mef});
      acc(7'h41, 16'h0010, 1'b0, 1'b1, smts_pkg::CYC_DATA, 1'b0, '0);
      for (int i = 0; i < 50 && (q_phys.size() != 0 || q_rd.size() != 0); i++) tick(1);
      if (q_phys.size() != 0 || q_rd.size() != 0) fail("results missing");
      results();
   end
endmodule // test_segment_mmu_table_select
